// *** shared/asc_pkg.sv ***
package asc_pkg;
	// Register byte addresses on the bus
	localparam logic [11:0] ASC_CTRL0_ADDR = 12'h000;
	localparam logic [11:0] ASC_CTRL1_ADDR = 12'h004;
	localparam logic [11:0] ASC_RESH_ADDR = 12'h008;
	localparam logic [11:0] ASC_RESL_ADDR = 12'h00C;
	// Field positions in converter_control_zero
	localparam int ASC_ENABLE_BIT = 0;
	localparam int ASC_GO_BIT = 1;
	localparam int ASC_CHAN_LSB = 2;
	localparam int ASC_CLKSEL_LSB = 6;
	// Field positions in converter_control_one
	localparam int ASC_POSREF_BIT = 4;
	localparam int ASC_NEGREF_BIT = 5;
	localparam int ASC_FORMAT_BIT = 7;
	localparam logic [7:0] ASC_CTRL1_MASK = 8'hB0;
	// Reset values
	localparam logic [7:0] ASC_CTRL0_RST = 8'h00;
	localparam logic [7:0] ASC_CTRL1_RST = 8'h00;
	// Clock select codes
	localparam logic [1:0] ASC_CLK_DIV2 = 2'h0;
	localparam logic [1:0] ASC_CLK_DIV8 = 2'h1;
	localparam logic [1:0] ASC_CLK_DIV32 = 2'h2;
	localparam logic [1:0] ASC_CLK_OSC = 2'h3;
	// Timing: system clock 25 MHz, oscillator at most 500 kHz
	localparam int ASC_SYS_KHZ = 25000;
	localparam int ASC_OSC_MAX_KHZ = 500;
	// Longest period rounds up so frequency stays at or below the maximum
	localparam int ASC_OSC_DIV = (ASC_SYS_KHZ + ASC_OSC_MAX_KHZ - 1) / ASC_OSC_MAX_KHZ;
	localparam int ASC_CONV_PERIODS = 11;
	localparam int ASC_ABORT_PERIODS = 2;
	typedef enum logic [2:0] {
		ASC_IDLE = 3'b001,
		ASC_CONV = 3'b010,
		ASC_WAIT = 3'b100
	} asc_state_type;
endpackage : asc_pkg

// *** rtl/asc_adc_ctrl.sv ***
`timescale 1ns/1ps
// How it works
// RULE1 - clock select picks div2, div8, div32, oscillator
// RULE2 - oscillator period derived at most 500 kHz
// RULE3 - four bit channel field drives analog mux
// RULE4 - writing go starts conversion, reads one meanwhile
// RULE5 - go clears itself when conversion finishes
// RULE6 - enable bit powers converter, clear holds off
// RULE7 - format bit one right, zero left
// RULE8 - negative reference pin or ground select
// RULE9 - positive reference pin or supply select
// RULE10 - left format high byte holds bits 9..2
// RULE11 - left format low byte top holds 1..0
// RULE12 - right format high byte low holds 9..8
// RULE13 - right format low byte holds 7..0
// RULE14 - software ignores reserved low result bits
// RULE15 - unused control one bits read zero
// RULE16 - reset clears controls, results stay unknown
// RULE17 - software waits acquisition before starting
// RULE18 - hold capacitor never discharged after conversion
// RULE19 - conversion lasts eleven conversion clock periods
// RULE20 - completion clears go, pulses flag, loads result
// RULE21 - abort keeps result, waits two periods
// RULE22 - special event trigger sets go itself
// RULE23 - done flag pulses on every completion
module asc_adc_ctrl
	import asc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic special_trigger,
	input wire logic [9:0] conversion_result,
	output logic converter_enable,
	output logic [3:0] input_channel_select,
	output logic pos_reference_select,
	output logic neg_reference_select,
	output logic hold_discharge,
	output logic conv_strobe,
	output logic conv_start,
	output logic conversion_done_flag
);
	typedef struct packed {
		logic [7:0] ctrl0;
		logic [7:0] ctrl1;
		logic [7:0] res_hi;
		logic [7:0] res_lo;
		asc_state_type state;
		logic [5:0] div_cnt;
		logic [3:0] tad_cnt;
		logic strobe;
		logic start;
		logic done;
		logic wr_pend;
		logic [11:0] wr_addr;
		logic [31:0] rdata;
	} asc_regs_type;

	asc_regs_type state_r;
	asc_regs_type state_nxt;
	logic [5:0] div_lim;
	logic tick;
	logic [7:0] wbyte;
	logic [11:0] a_addr;
	logic go_clr;

	// Conversion clock divider limit per selection
	always_comb begin
		case (state_r.ctrl0[ASC_CLKSEL_LSB +: 2]) // RULE1
			ASC_CLK_DIV2: div_lim = 6'd1;
			ASC_CLK_DIV8: div_lim = 6'd7;
			ASC_CLK_DIV32: div_lim = 6'd31;
			default: div_lim = 6'(ASC_OSC_DIV - 1); // RULE2
		endcase
	end

	assign tick = (state_r.div_cnt >= div_lim);
	assign wbyte = hwdata[7:0];
	assign a_addr = haddr[11:0];
	// Software write of zero to go while busy is an abort
	assign go_clr = state_r.wr_pend && (state_r.wr_addr == ASC_CTRL0_ADDR)
		&& !wbyte[ASC_GO_BIT];

	// Next state: bus slave, go bit, conversion sequencer
	always_comb begin
		state_nxt = state_r;
		state_nxt.strobe = 1'b0;
		state_nxt.start = 1'b0;
		state_nxt.done = 1'b0;
		state_nxt.div_cnt = tick ? 6'd0 : state_r.div_cnt + 6'd1;
		// Address phase capture; zero wait states
		state_nxt.wr_pend = hsel && hready && htrans[1] && hwrite;
		if (hsel && hready && htrans[1]) begin
			state_nxt.wr_addr = a_addr;
			if (a_addr == ASC_CTRL0_ADDR) begin
				state_nxt.rdata = {24'h000000, state_r.ctrl0};
			end else if (a_addr == ASC_CTRL1_ADDR) begin
				state_nxt.rdata = {24'h000000, state_r.ctrl1 & ASC_CTRL1_MASK}; // RULE15
			end else if (a_addr == ASC_RESH_ADDR) begin
				state_nxt.rdata = {24'h000000, state_r.res_hi};
			end else if (a_addr == ASC_RESL_ADDR) begin
				state_nxt.rdata = {24'h000000, state_r.res_lo};
			end else begin
				state_nxt.rdata = 32'h00000000;
			end
		end
		// Data phase write
		if (state_r.wr_pend) begin
			if (state_r.wr_addr == ASC_CTRL0_ADDR) begin
				state_nxt.ctrl0 = wbyte;
			end else if (state_r.wr_addr == ASC_CTRL1_ADDR) begin
				state_nxt.ctrl1 = wbyte & ASC_CTRL1_MASK; // RULE15
			end else if (state_r.wr_addr == ASC_RESH_ADDR) begin
				state_nxt.res_hi = wbyte;
			end else if (state_r.wr_addr == ASC_RESL_ADDR) begin
				state_nxt.res_lo = wbyte;
			end
		end
		// Sequencer: idle until enable, go and a tick, then eleven ticks of conversion
		// An abort parks in the wait state so the hold capacitor can settle
		case (state_r.state)
			ASC_IDLE: begin
				state_nxt.tad_cnt = 4'd0;
				if (state_r.ctrl0[ASC_GO_BIT] && state_r.ctrl0[ASC_ENABLE_BIT] && tick) begin
					state_nxt.state = ASC_CONV; // RULE4
					state_nxt.start = 1'b1;
				end
			end
			ASC_CONV: begin
				if (!state_r.ctrl0[ASC_ENABLE_BIT] || go_clr) begin
					// Abort: result untouched
					state_nxt.state = ASC_WAIT; // RULE21
					state_nxt.tad_cnt = 4'd0;
					state_nxt.ctrl0[ASC_GO_BIT] = 1'b0;
				end else if (tick) begin
					state_nxt.strobe = 1'b1;
					state_nxt.tad_cnt = state_r.tad_cnt + 4'd1;
					if (state_r.tad_cnt == 4'(ASC_CONV_PERIODS - 1)) begin // RULE19
						state_nxt.state = ASC_IDLE;
						state_nxt.done = 1'b1; // RULE20 RULE23
						state_nxt.ctrl0[ASC_GO_BIT] = 1'b0; // RULE5
						if (state_r.ctrl1[ASC_FORMAT_BIT]) begin // RULE7
							state_nxt.res_hi = {6'h00, conversion_result[9:8]}; // RULE12
							state_nxt.res_lo = conversion_result[7:0]; // RULE13
						end else begin
							state_nxt.res_hi = conversion_result[9:2]; // RULE10
							state_nxt.res_lo = {conversion_result[1:0], 6'h00}; // RULE11
						end
					end
				end
			end
			ASC_WAIT: begin
				if (tick) begin
					state_nxt.tad_cnt = state_r.tad_cnt + 4'd1;
					if (state_r.tad_cnt == 4'(ASC_ABORT_PERIODS - 1)) begin
						state_nxt.state = ASC_IDLE; // RULE21
					end
				end
			end
			default: state_nxt.state = ASC_IDLE;
		endcase
		// Hardware trigger sets go last, so it wins over any clear this cycle
		if (special_trigger && state_r.ctrl0[ASC_ENABLE_BIT]) begin
			state_nxt.ctrl0[ASC_GO_BIT] = 1'b1; // RULE22
		end
	end

	// State register; results are not reset so they start unknown
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r.ctrl0 <= ASC_CTRL0_RST; // RULE16
			state_r.ctrl1 <= ASC_CTRL1_RST; // RULE16
			state_r.state <= ASC_IDLE;
			state_r.div_cnt <= 6'd0;
			state_r.tad_cnt <= 4'd0;
			state_r.strobe <= 1'b0;
			state_r.start <= 1'b0;
			state_r.done <= 1'b0;
			state_r.wr_pend <= 1'b0;
			state_r.wr_addr <= 12'h000;
			state_r.rdata <= 32'h00000000;
			state_r.res_hi <= state_nxt.res_hi;
			state_r.res_lo <= state_nxt.res_lo;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Outputs straight from flops; bus ready, response and hold discharge tied constant
	assign hrdata = state_r.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign converter_enable = state_r.ctrl0[ASC_ENABLE_BIT]; // RULE6
	assign input_channel_select = state_r.ctrl0[ASC_CHAN_LSB +: 4]; // RULE3
	assign pos_reference_select = state_r.ctrl1[ASC_POSREF_BIT]; // RULE9
	assign neg_reference_select = state_r.ctrl1[ASC_NEGREF_BIT]; // RULE8
	assign hold_discharge = 1'b0; // RULE18
	assign conv_strobe = state_r.strobe;
	assign conv_start = state_r.start;
	assign conversion_done_flag = state_r.done;

	// Checks
	conv_len_a: assert property (@(posedge clk) disable iff (rst) // RULE19
		conv_start |-> !conversion_done_flag [*3])
		else $error("done too early after start");
	done_go_a: assert property (@(posedge clk) disable iff (rst) // RULE5
		conversion_done_flag |-> !state_r.ctrl0[ASC_GO_BIT] || $past(special_trigger))
		else $error("go still set at done");
	start_en_a: assert property (@(posedge clk) disable iff (rst) // RULE4
		conv_start |-> $past(converter_enable))
		else $error("start while disabled");
	ctrl1_zero_a: assert property (@(posedge clk) disable iff (rst) // RULE15
		(state_r.ctrl1 & ~ASC_CTRL1_MASK) == 8'h00)
		else $error("unused control bits set");
	left_fmt_a: assert property (@(posedge clk) disable iff (rst) // RULE11
		conversion_done_flag && !state_r.ctrl1[ASC_FORMAT_BIT]
		|-> state_r.res_lo[5:0] == 6'h00 && state_r.res_hi == $past(conversion_result[9:2]))
		else $error("left format wrong");
	right_fmt_a: assert property (@(posedge clk) disable iff (rst) // RULE12
		conversion_done_flag && state_r.ctrl1[ASC_FORMAT_BIT]
		|-> state_r.res_hi[7:2] == 6'h00 && state_r.res_lo == $past(conversion_result[7:0]))
		else $error("right format wrong");
	done_pulse_a: assert property (@(posedge clk) disable iff (rst) // RULE23
		conversion_done_flag |=> !conversion_done_flag)
		else $error("done not a pulse");
	abort_wait_a: assert property (@(posedge clk) disable iff (rst) // RULE21
		state_r.state == ASC_CONV && go_clr && converter_enable
		|=> state_r.state == ASC_WAIT && !conversion_done_flag)
		else $error("abort not handled");
	trig_go_a: assert property (@(posedge clk) disable iff (rst) // RULE22
		special_trigger && converter_enable |=> state_r.ctrl0[ASC_GO_BIT])
		else $error("trigger ignored");
	no_dis_a: assert property (@(posedge clk) disable iff (rst) // RULE18
		!hold_discharge)
		else $error("hold discharged");
	conv_done_c: cover property (@(posedge clk) disable iff (rst) conversion_done_flag);
	abort_c: cover property (@(posedge clk) disable iff (rst) state_r.state == ASC_WAIT);
	trig_c: cover property (@(posedge clk) disable iff (rst) special_trigger && conv_start);
	right_done_c: cover property (@(posedge clk) disable iff (rst)
		conversion_done_flag && state_r.ctrl1[ASC_FORMAT_BIT]);
	osc_done_c: cover property (@(posedge clk) disable iff (rst)
		conversion_done_flag && state_r.ctrl0[ASC_CLKSEL_LSB +: 2] == ASC_CLK_OSC);

	// Sequencer shape: exactly one state at a time
	state_hot_a: assert property (@(posedge clk) disable iff (rst) // RULE4
		$onehot(state_r.state))
		else $error("sequencer state not one-hot");

	// A start only leaves idle and begins at the first period
	start_idle_a: assert property (@(posedge clk) disable iff (rst) // RULE4
		conv_start |-> state_r.state == ASC_CONV && state_r.tad_cnt == 4'd0
		&& $past(state_r.state) == ASC_IDLE)
		else $error("start not from idle");

	// A start needs go set beforehand
	start_go_a: assert property (@(posedge clk) disable iff (rst) // RULE4
		conv_start |-> $past(state_r.ctrl0[ASC_GO_BIT]))
		else $error("start without go");

	// Go reads one all through a conversion
	busy_go_a: assert property (@(posedge clk) disable iff (rst) // RULE4
		state_r.state == ASC_CONV |-> state_r.ctrl0[ASC_GO_BIT])
		else $error("go low while converting");

	// Strobes come only out of the converting state
	strobe_conv_a: assert property (@(posedge clk) disable iff (rst) // RULE19
		conv_strobe |-> $past(state_r.state) == ASC_CONV)
		else $error("strobe outside conversion");

	// Period counter never passes the conversion length
	tad_range_a: assert property (@(posedge clk) disable iff (rst) // RULE19
		state_r.state == ASC_CONV |-> state_r.tad_cnt < 4'(ASC_CONV_PERIODS))
		else $error("period count overrun");

	// Completion lands on the last strobe
	done_strobe_a: assert property (@(posedge clk) disable iff (rst) // RULE19
		conversion_done_flag |-> conv_strobe)
		else $error("done without last strobe");

	// Fastest clock still gives strobes at least two cycles apart
	strobe_gap_a: assert property (@(posedge clk) disable iff (rst) // RULE1
		conv_strobe |-> !$past(conv_strobe))
		else $error("strobes back to back");

	// Divider never counts past the slowest setting
	div_range_a: assert property (@(posedge clk) disable iff (rst) // RULE2
		state_r.div_cnt <= 6'(ASC_OSC_DIV - 1))
		else $error("divider overrun");

	// Completion returns to idle from a conversion
	done_idle_a: assert property (@(posedge clk) disable iff (rst) // RULE20
		conversion_done_flag |-> state_r.state == ASC_IDLE
		&& $past(state_r.state) == ASC_CONV)
		else $error("done from wrong state");

	// Abort wait ends after its second period
	wait_exit_a: assert property (@(posedge clk) disable iff (rst) // RULE21
		state_r.state == ASC_WAIT && tick && state_r.tad_cnt == 4'(ASC_ABORT_PERIODS - 1)
		|=> state_r.state == ASC_IDLE)
		else $error("abort wait too long");

	// Abort wait does not end between ticks
	wait_hold_a: assert property (@(posedge clk) disable iff (rst) // RULE21
		state_r.state == ASC_WAIT && !tick |=> state_r.state == ASC_WAIT)
		else $error("abort wait cut short");

	// No new conversion straight out of the wait
	wait_start_a: assert property (@(posedge clk) disable iff (rst) // RULE21
		state_r.state == ASC_WAIT |=> !conv_start)
		else $error("start during abort wait");

	// Clearing enable mid-conversion aborts it
	dis_abort_a: assert property (@(posedge clk) disable iff (rst) // RULE6
		state_r.state == ASC_CONV && !converter_enable |=> state_r.state == ASC_WAIT)
		else $error("disable did not abort");

	// A disabled converter never starts
	off_start_a: assert property (@(posedge clk) disable iff (rst) // RULE6
		!converter_enable |=> !conv_start)
		else $error("start while off");

	// Right format puts the top two bits low in the high byte
	right_hi_a: assert property (@(posedge clk) disable iff (rst) // RULE12
		conversion_done_flag && $past(state_r.ctrl1[ASC_FORMAT_BIT])
		|-> state_r.res_hi[1:0] == $past(conversion_result[9:8]))
		else $error("right high byte wrong");

	// Left format puts the bottom two bits on top of the low byte
	left_lo_a: assert property (@(posedge clk) disable iff (rst) // RULE11
		conversion_done_flag && !$past(state_r.ctrl1[ASC_FORMAT_BIT])
		|-> state_r.res_lo[7:6] == $past(conversion_result[1:0]))
		else $error("left low byte wrong");

	// Registers are one byte wide; the rest of the word reads zero
	rdata_upper_a: assert property (@(posedge clk) disable iff (rst) // RULE15
		hrdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
endmodule : asc_adc_ctrl

// *** test/asc_far_model.sv ***
`timescale 1ns/1ps
// Analog front end: returns the sample presented at conversion start
module asc_far_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic conv_start,
	input wire logic conversion_done_flag,
	input wire logic [9:0] next_sample,
	output logic [9:0] conversion_result
);
	logic [9:0] held_r;
	logic busy_r;
	// Capture at start, release after completion
	always @(posedge clk) begin
		if (rst) begin
			busy_r <= 1'h0;
			held_r <= 10'h155;
		end else if (conv_start) begin
			held_r <= next_sample;
			busy_r <= 1'h1;
		end else if (conversion_done_flag) begin
			busy_r <= 1'h0;
		end
	end
	// Outside a conversion the value is stale, so show its inverse
	assign conversion_result = busy_r ? held_r : ~held_r;
endmodule : asc_far_model

// *** test/tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
	import asc_pkg::*;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, special_trigger = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 0;
	logic hreadyout, hresp, converter_enable, pos_reference_select, neg_reference_select;
	logic hold_discharge, conv_strobe, conv_start, conversion_done_flag;
	logic [3:0] input_channel_select, ch = 0;
	logic [9:0] conversion_result, samp = 0;
	int err_total = 0, check_count = 0, seed = 78019;
	int cyc = 0, dur = 0, sgap = 0, lastgap = 0, ndone = 0, n0 = 0;
	int mres[$];
	asc_adc_ctrl i_asc_adc_ctrl (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .special_trigger, .conversion_result,
		.converter_enable, .input_channel_select, .pos_reference_select, .neg_reference_select,
		.hold_discharge, .conv_strobe, .conv_start, .conversion_done_flag);
	asc_far_model i_asc_far_model (.clk, .rst, .conv_start, .conversion_done_flag,
		.next_sample(samp), .conversion_result);
	// 25 MHz system clock
	initial begin
		forever #20 clk = ~clk;
	end
	// Tracks strobe spacing, conversion length and completion pulses
	always @(posedge clk) begin
		sgap <= conv_strobe ? 0 : sgap + 1;
		if (conv_strobe) lastgap <= sgap + 1;
		cyc <= conv_start ? 1 : cyc + 1;
		if (conversion_done_flag) begin
			dur <= cyc;
			ndone <= ndone + 1;
		end
	end
	task finish_test;
		if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	// Bounded wait for hready; a hang ends the run as a failure
	task hw;
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (hreadyout !== 1'h1 && i < 50);
		if (hreadyout !== 1'h1) begin
			err_total++;
			finish_test();
		end
	endtask : hw
	// One single-word transfer; read data lands in r
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'h1; htrans <= 2'h2; haddr <= {20'h0, a}; hwrite <= w; hsize <= 3'h2;
		hw();
		hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
		hw();
		r = hrdata;
		// Let the edge's updates settle before callers look at outputs
		#1;
	endtask : bus
	task waitdone;
		int i;
		n0 = ndone;
		for (i = 0; i < 1000 && ndone == n0; i++) @(posedge clk);
		if (ndone == n0) begin
			err_total++;
			finish_test();
		end
		repeat (2) @(posedge clk);
	endtask : waitdone
	// Reserved bits are masked off; only documented result bits compared
	task chkres(input logic fmt);
		int s;
		s = mres[$];
		bus(1'h0, ASC_RESH_ADDR, 32'h0);
		`CHK("res high", fmt ? s >> 8 : s >> 2, r & (fmt ? 3 : 255))
		bus(1'h0, ASC_RESL_ADDR, 32'h0);
		`CHK("res low", fmt ? s & 255 : (s & 3) << 6, r & (fmt ? 255 : 192))
	endtask : chkres
	task conv(input logic [1:0] code, input logic fmt);
		int dv;
		dv = (code == 0) ? 2 : (code == 1) ? 8 : (code == 2) ? 32 : ASC_OSC_DIV;
		bus(1'h1, ASC_CTRL1_ADDR, fmt ? 32'h80 : 32'h30);
		ch = $random(seed);
		samp = $random(seed);
		bus(1'h1, ASC_CTRL0_ADDR, {24'h0, code, ch, 2'h1});
		`CHK("channel", ch, input_channel_select)
		repeat (20) @(posedge clk);
		bus(1'h1, ASC_CTRL0_ADDR, {24'h0, code, ch, 2'h3});
		bus(1'h0, ASC_CTRL0_ADDR, 32'h0);
		`CHK("busy", 1'h1, r[1])
		waitdone();
		mres.push_back(samp);
		`CHK("length", 11 * dv, dur)
		`CHK("spacing", dv, lastgap)
		`CHK("one pulse", n0 + 1, ndone)
		bus(1'h0, ASC_CTRL0_ADDR, 32'h0);
		`CHK("go clear", 1'h0, r[1])
		chkres(fmt);
	endtask : conv
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		bus(1'h0, ASC_CTRL0_ADDR, 32'h0);
		`CHK("ctrl0 reset", 32'h0, r)
		bus(1'h0, ASC_CTRL1_ADDR, 32'h0);
		`CHK("ctrl1 reset", 32'h0, r)
		bus(1'h1, ASC_CTRL1_ADDR, 32'hFF);
		bus(1'h0, ASC_CTRL1_ADDR, 32'h0);
		`CHK("ctrl1 read", 32'hB0, r)
		`CHK("refs", 2'h3, {neg_reference_select, pos_reference_select})
		bus(1'h0, 12'h010, 32'h0);
		`CHK("unmapped", 32'h0, r)
		for (int k = 0; k < 8; k++) conv(k[1:0], k[2]);
		// Abort mid-run: old result must survive
		samp = samp ^ 10'h3FF;
		bus(1'h1, ASC_CTRL0_ADDR, {24'h0, ASC_CLK_DIV32, ch, 2'h3});
		n0 = ndone;
		repeat (40) @(posedge clk);
		bus(1'h1, ASC_CTRL0_ADDR, {24'h0, ASC_CLK_DIV32, ch, 2'h1});
		repeat (500) @(posedge clk);
		`CHK("abort", n0, ndone)
		chkres(1'h1);
		// Hardware trigger starts a conversion without software
		samp = $random(seed);
		@(posedge clk);
		special_trigger <= 1'h1;
		@(posedge clk);
		special_trigger <= 1'h0;
		waitdone();
		mres.push_back(samp);
		chkres(1'h1);
		bus(1'h1, ASC_CTRL0_ADDR, 32'h0);
		`CHK("disable", 1'h0, converter_enable)
		`CHK("hold", 1'h0, hold_discharge)
		finish_test();
	end
endmodule : tb
